/* sles_consts.svh */
// register map, field and reset constants for the lane status block
`ifndef SLES_CONSTS_SVH
`define SLES_CONSTS_SVH

`define SLES_LANES 8
`define SLES_LINKS 2
`define SLES_FLAT 16
`define SLES_ADDR_W 16

// register indices, byte address is index times four
`define SLES_IDX_LINK_PAGE 14'h0300
`define SLES_IDX_ERR_FLAGS 14'h046F
`define SLES_IDX_LOCK_FLAGS 14'h0470
`define SLES_IDX_THRESHOLD 14'h0480
`define SLES_IDX_CTRL 14'h0481
`define SLES_IDX_IRQ_STS 14'h0482
`define SLES_IDX_IRQ_MASK 14'h0483

`define SLES_RST_FLAGS 8'h00
`define SLES_RST_THR 8'hFF
`define SLES_RST_PAGE 1'h0
`define SLES_RST_IRQ 16'h0000
`define SLES_CNT_MAX 8'hFF
`define SLES_CTRL_CLR_BIT 0

`endif

/* sles_pkg.sv */
// shared types for the lane status block
package sles_pkg;
   typedef logic [7:0] sles_byte_t;
   typedef logic [15:0] sles_lanes_t;
   typedef logic [31:0] sles_word_t;
endpackage

/* sles_lane_cnt.sv */
// per-lane control character error counter with threshold compare and lock flag
`include "sles_consts.svh"

module sles_lane_cnt (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic err_evt,
   input wire logic cnt_clr,
   input wire sles_pkg::sles_byte_t threshold,
   input wire logic lock_in,
   output sles_pkg::sles_byte_t err_cnt,
   output logic err_flag,
   output logic lock_flag
);

   sles_pkg::sles_byte_t cnt_r;
   sles_pkg::sles_byte_t cnt_nxt;
   logic err_flag_r;
   logic lock_flag_r;
   wire logic at_max = (cnt_r == `SLES_CNT_MAX);

   // saturating count of unexpected control characters
   assign cnt_nxt = cnt_clr ? `SLES_RST_FLAGS :
                    (err_evt && !at_max) ? cnt_r + 8'h01 : cnt_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= `SLES_RST_FLAGS;
         err_flag_r <= 1'b0;
         lock_flag_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         err_flag_r <= (cnt_r >= threshold);
         lock_flag_r <= lock_in;
      end
   end

   assign err_cnt = cnt_r;
   assign err_flag = err_flag_r;
   assign lock_flag = lock_flag_r;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_FLAG_VS_THRESHOLD: assert property (
      ##1 err_flag == ($past(cnt_r) >= $past(threshold)))
      else $error("error flag does not follow count versus threshold");

   AST_COUNT_STEP: assert property (
      err_evt && !cnt_clr && !at_max |=> cnt_r == $past(cnt_r) + 8'h01)
      else $error("counter did not advance on an error event");

   AST_COUNT_HOLD: assert property (
      !err_evt && !cnt_clr |=> $stable(cnt_r))
      else $error("counter moved without an event");

endmodule

/* sles_top.sv */
// lane error and code group lock status registers behind an apb slave
// How it works
// - one read-only error flag per lane, bit equals lane, reset zero
// - flag is 0 below the eight-bit threshold, 1 at or above it
// - reads return the flags of the link chosen by the page register
// - read-only lock flag per lane, 1 locked, 0 lost, reset zero
`include "sles_consts.svh"

module sles_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SLES_ADDR_W-1:0] paddr,
   input wire sles_pkg::sles_word_t pwdata,
   output sles_pkg::sles_word_t prdata,
   output logic pready,
   output logic pslverr,
   input wire sles_pkg::sles_lanes_t lane_kchar_err,
   input wire sles_pkg::sles_lanes_t lane_cg_lock,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic page_r;
   sles_pkg::sles_byte_t thr_r;
   sles_pkg::sles_lanes_t irq_sts_r;
   sles_pkg::sles_lanes_t irq_sts_nxt;
   sles_pkg::sles_lanes_t irq_mask_r;
   sles_pkg::sles_word_t prdata_r;
   logic pslverr_r;
   sles_pkg::sles_lanes_t err_flags;
   sles_pkg::sles_lanes_t err_flags_d_r;
   sles_pkg::sles_lanes_t lock_flags;
   logic cnt_clr_r;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic [13:0] idx = paddr[15:2];
   wire logic setup = psel && !penable;
   wire logic access = psel && penable;
   wire logic wr_acc = access && pwrite;
   wire logic rd_acc = access && !pwrite;
   wire logic hit_page = (idx == `SLES_IDX_LINK_PAGE);
   wire logic hit_err = (idx == `SLES_IDX_ERR_FLAGS);
   wire logic hit_lock = (idx == `SLES_IDX_LOCK_FLAGS);
   wire logic hit_thr = (idx == `SLES_IDX_THRESHOLD);
   wire logic hit_ctrl = (idx == `SLES_IDX_CTRL);
   wire logic hit_sts = (idx == `SLES_IDX_IRQ_STS);
   wire logic hit_mask = (idx == `SLES_IDX_IRQ_MASK);
   wire logic hit_any = hit_page || hit_err || hit_lock || hit_thr || hit_ctrl ||
                        hit_sts || hit_mask;
   wire logic read_only = hit_err || hit_lock || hit_sts;
   wire logic bad_acc = !hit_any || (pwrite && read_only);

   // selected link page
   wire sles_pkg::sles_byte_t sel_err = err_flags[page_r*`SLES_LANES +: `SLES_LANES];
   wire sles_pkg::sles_byte_t sel_lock = lock_flags[page_r*`SLES_LANES +: `SLES_LANES];

   // per-lane bits of the selected link, bit position equals lane
   wire logic ctrl_char_err_lane0 = sel_err[0];
   wire logic ctrl_char_err_lane1 = sel_err[1];
   wire logic ctrl_char_err_lane2 = sel_err[2];
   wire logic ctrl_char_err_lane3 = sel_err[3];
   wire logic ctrl_char_err_lane4 = sel_err[4];
   wire logic ctrl_char_err_lane5 = sel_err[5];
   wire logic ctrl_char_err_lane6 = sel_err[6];
   wire logic ctrl_char_err_lane7 = sel_err[7];
   wire logic code_group_lock_lane5 = sel_lock[5];
   wire logic code_group_lock_lane6 = sel_lock[6];
   wire logic code_group_lock_lane7 = sel_lock[7];
   wire sles_pkg::sles_byte_t err_field = {ctrl_char_err_lane7, ctrl_char_err_lane6,
      ctrl_char_err_lane5, ctrl_char_err_lane4, ctrl_char_err_lane3, ctrl_char_err_lane2,
      ctrl_char_err_lane1, ctrl_char_err_lane0};
   wire sles_pkg::sles_byte_t lock_field = {code_group_lock_lane7, code_group_lock_lane6,
      code_group_lock_lane5, sel_lock[4:0]};

   // read words, data in the low bits, upper bits zero
   wire sles_pkg::sles_word_t rd_page = {31'h00000000, page_r};
   wire sles_pkg::sles_word_t rd_err = {24'h000000, err_field};
   wire sles_pkg::sles_word_t rd_lock = {24'h000000, lock_field};
   wire sles_pkg::sles_word_t rd_thr = {24'h000000, thr_r};
   wire sles_pkg::sles_word_t rd_sts = {16'h0000, irq_sts_r};
   wire sles_pkg::sles_word_t rd_mask = {16'h0000, irq_mask_r};

   wire sles_pkg::sles_word_t rd_mux =
      hit_page ? rd_page :
      hit_err ? rd_err :
      hit_lock ? rd_lock :
      hit_thr ? rd_thr :
      hit_sts ? rd_sts :
      hit_mask ? rd_mask : 32'h00000000;

   // rising error flags raise sticky status, set beats read clear
   wire sles_pkg::sles_lanes_t flag_rise = err_flags & ~err_flags_d_r;
   wire logic sts_clr = rd_acc && hit_sts;
   assign irq_sts_nxt = (sts_clr ? 16'h0000 : irq_sts_r) | flag_rise;

   ////////////////////////////////////////////////////////////////////////////
   // per-lane counters for every link
   genvar g;
   generate
      for (g = 0; g < `SLES_FLAT; g++) begin : g_lane
         sles_lane_cnt u_lane (
            .clk(clk),
            .sys_rst(sys_rst),
            .err_evt(lane_kchar_err[g]),
            .cnt_clr(cnt_clr_r),
            .threshold(thr_r),
            .lock_in(lane_cg_lock[g]),
            .err_cnt(),
            .err_flag(err_flags[g]),
            .lock_flag(lock_flags[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // write side
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         page_r <= `SLES_RST_PAGE;
         thr_r <= `SLES_RST_THR;
         irq_mask_r <= `SLES_RST_IRQ;
         cnt_clr_r <= 1'b0;
      end else begin
         if (wr_acc && hit_page) begin
            page_r <= pwdata[0];
         end
         if (wr_acc && hit_thr) begin
            thr_r <= pwdata[7:0];
         end
         if (wr_acc && hit_mask) begin
            irq_mask_r <= pwdata[15:0];
         end
         cnt_clr_r <= wr_acc && hit_ctrl && pwdata[`SLES_CTRL_CLR_BIT];
      end
   end

   // read side and status
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
         irq_sts_r <= `SLES_RST_IRQ;
         err_flags_d_r <= `SLES_RST_IRQ;
      end else begin
         if (setup) begin
            prdata_r <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_r <= bad_acc;
         end
         irq_sts_r <= irq_sts_nxt;
         err_flags_d_r <= err_flags;
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = pslverr_r && access;
   assign irq = |(irq_sts_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_ERR_READ_PAGED: assert property (
      setup && !pwrite && hit_err |=> prdata == {24'h000000, $past(sel_err)})
      else $error("error flag read does not match selected link");

   AST_LOCK_READ_PAGED: assert property (
      setup && !pwrite && hit_lock |=> prdata[7:0] == $past(sel_lock))
      else $error("lock flag read does not match selected link");

   AST_LOCK_FOLLOWS: assert property (
      ##1 (lock_flags == $past(lane_cg_lock) || $past(sys_rst)))
      else $error("lock flags lag the lanes by other than one cycle");

   AST_ERR_UPPER_ZERO: assert property (
      access && !pwrite && hit_err |-> prdata[31:8] == 24'h000000)
      else $error("error register upper bits not zero");

   AST_FLAGS_CLEAR_AFTER_RESET: assert property (
      disable iff (1'b0) $past(sys_rst) && !sys_rst |-> err_flags == 16'h0000)
      else $error("error flags not zero after reset");

   AST_IRQ_RAISE: assert property (
      flag_rise != 16'h0000 && (flag_rise & irq_mask_r) != 16'h0000 |=> irq)
      else $error("masked-in error rise did not raise interrupt");

   ////////////////////////////////////////////////////////////////////////////
   // register behaviour checks
   AST_PAGE_WRITE: assert property (
      wr_acc && hit_page |=> page_r == $past(pwdata[0]))
      else $error("page register did not take the written bit");

   AST_PAGE_HOLD: assert property (
      !(wr_acc && hit_page) |=> $stable(page_r))
      else $error("page register changed without a write");

   AST_THR_WRITE: assert property (
      wr_acc && hit_thr |=> thr_r == $past(pwdata[7:0]))
      else $error("threshold did not take the written byte");

   AST_THR_HOLD: assert property (
      !(wr_acc && hit_thr) |=> $stable(thr_r))
      else $error("threshold changed without a write");

   AST_MASK_WRITE: assert property (
      wr_acc && hit_mask |=> irq_mask_r == $past(pwdata[15:0]))
      else $error("mask did not take the written half word");

   AST_MASK_HOLD: assert property (
      !(wr_acc && hit_mask) |=> $stable(irq_mask_r))
      else $error("mask changed without a write");

   AST_RO_WRITE_IGNORED: assert property (
      wr_acc && read_only |=> $stable(page_r) && $stable(thr_r) && $stable(irq_mask_r) &&
         !cnt_clr_r)
      else $error("write to a read-only register changed state");

   AST_SLVERR_UNMAPPED: assert property (
      access && !hit_any |-> pslverr)
      else $error("unmapped access without error response");

   AST_SLVERR_RO_WRITE: assert property (
      access && pwrite && read_only |-> pslverr)
      else $error("read-only write without error response");

   AST_SLVERR_CLEAN: assert property (
      access && hit_any && !(pwrite && read_only) |-> !pslverr)
      else $error("error response on a legal access");

   AST_SLVERR_IDLE: assert property (
      !access |-> !pslverr)
      else $error("error response outside the access phase");

   AST_PRDATA_HOLD: assert property (
      !setup |=> $stable(prdata))
      else $error("read data changed outside a setup cycle");

   AST_WRITE_READS_ZERO: assert property (
      setup && pwrite |=> prdata == 32'h00000000)
      else $error("read data not zero during a write");

   AST_THR_READ: assert property (
      setup && !pwrite && hit_thr |=> prdata == {24'h000000, $past(thr_r)})
      else $error("threshold read mismatch");

   AST_PAGE_READ: assert property (
      setup && !pwrite && hit_page |=> prdata == {31'h00000000, $past(page_r)})
      else $error("page read mismatch");

   AST_STS_READ: assert property (
      setup && !pwrite && hit_sts |=> prdata == {16'h0000, $past(irq_sts_r)})
      else $error("status read mismatch");

   AST_MASK_READ: assert property (
      setup && !pwrite && hit_mask |=> prdata == {16'h0000, $past(irq_mask_r)})
      else $error("mask read mismatch");

   AST_CTRL_READ_ZERO: assert property (
      setup && !pwrite && hit_ctrl |=> prdata == 32'h00000000)
      else $error("control register did not read zero");

   AST_UNMAPPED_READ: assert property (
      setup && !pwrite && !hit_any |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");

   AST_LOCK_UPPER_ZERO: assert property (
      access && !pwrite && hit_lock |-> prdata[31:8] == 24'h000000)
      else $error("lock register upper bits not zero");

   AST_STS_SET_WINS: assert property (
      flag_rise != 16'h0000 |=> (irq_sts_r & $past(flag_rise)) == $past(flag_rise))
      else $error("error rise did not set its status bit");

   AST_STS_STICKY: assert property (
      !sts_clr |=> (irq_sts_r & $past(irq_sts_r)) == $past(irq_sts_r))
      else $error("status bit dropped without a read");

   AST_STS_CLEARED: assert property (
      sts_clr && flag_rise == 16'h0000 |=> irq_sts_r == 16'h0000)
      else $error("status read did not clear the status");

   AST_STS_NO_SPURIOUS: assert property (
      1'b1 |=> (irq_sts_r & ~$past(irq_sts_r) & ~$past(flag_rise)) == 16'h0000)
      else $error("status bit set without an error rise");

   AST_CLR_FROM_CTRL: assert property (
      wr_acc && hit_ctrl && pwdata[`SLES_CTRL_CLR_BIT] |=> cnt_clr_r)
      else $error("counter clear write did not raise the clear");

   AST_CLR_ONE_CYCLE: assert property (
      cnt_clr_r |=> !cnt_clr_r)
      else $error("counter clear lasted more than one cycle");

   AST_CLEAR_DROPS_FLAGS: assert property (
      cnt_clr_r ##1 (thr_r != 8'h00) |=> err_flags == 16'h0000)
      else $error("error flags survived a counter clear");

   AST_IRQ_FALLS_ON_CLEAR: assert property (
      sts_clr && flag_rise == 16'h0000 |=> !irq)
      else $error("interrupt stayed high after the status read");

   COV_COUNT_CLEAR: cover property (cnt_clr_r && err_flags != 16'h0000);
   COV_PAGE_ONE_READ: cover property (setup && !pwrite && hit_err && page_r);
   COV_FLAG_RISE: cover property (flag_rise != 16'h0000);
   COV_STS_CLEAR: cover property (sts_clr && irq_sts_r != 16'h0000);
   COV_LOCK_LOST: cover property ($fell(lock_flags[7]));

endmodule

/* sles_lane_tx.sv */
// transmitter-side model driving lane error pulses and lock levels
module sles_lane_tx (
   input wire logic clk,
   output sles_pkg::sles_lanes_t kchar_err,
   output sles_pkg::sles_lanes_t cg_lock
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      kchar_err = 16'h0000;
      cg_lock = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // n back-to-back one-cycle error pulses on bit b
   task automatic send(input int b, input int n);
      repeat (n) begin
         @(posedge clk);
         kchar_err <= 16'h0001 << b;
      end
      @(posedge clk);
      kchar_err <= 16'h0000;
   endtask

   // lock levels for all lanes of both links
   task automatic set_lock(input sles_pkg::sles_lanes_t v);
      @(posedge clk);
      cg_lock <= v;
   endtask
endmodule

/* tb.sv */
// self-checking bench for the lane status block
`include "sles_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   sles_pkg::sles_word_t pwdata = 32'h00000000;
   sles_pkg::sles_word_t prdata;
   logic pready, pslverr, irq;
   sles_pkg::sles_lanes_t kerr, lock, v;
   int n_errors = 0;
   int checks_done = 0;
   int seed = 32'hBCD5;
   logic [33:0] q[$];
   logic [33:0] n;

   initial forever #5 clk = ~clk;

   sles_top dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lane_kchar_err(kerr), .lane_cg_lock(lock), .irq(irq));
   sles_lane_tx tx_u (.clk(clk), .kchar_err(kerr), .cg_lock(lock));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_word(input sles_pkg::sles_word_t g, input sles_pkg::sles_word_t e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_bit(input logic g, input logic e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // apb transfer; the note holds read flag, expected error and data
   task automatic apb(input logic w, input logic [13:0] idx, input sles_pkg::sles_word_t d,
      input logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      q.push_back({~w, e, d});
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         n = q.pop_front();
         chk_bit(pslverr, n[32]);
         if (n[33]) chk_word(prdata, n[31:0]);
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #50000;
      n_errors++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      apb(0, `SLES_IDX_ERR_FLAGS, 32'h00000000, 0);
      apb(0, `SLES_IDX_LOCK_FLAGS, 32'h00000000, 0);
      apb(0, `SLES_IDX_THRESHOLD, 32'h000000FF, 0);
      apb(1, `SLES_IDX_ERR_FLAGS, 32'h000000FF, 1);
      apb(1, `SLES_IDX_LOCK_FLAGS, 32'h000000FF, 1);
      apb(1, `SLES_IDX_IRQ_STS, 32'h0000FFFF, 1);
      apb(0, `SLES_IDX_CTRL, 32'h00000000, 0);
      apb(0, 14'h0100, 32'h00000000, 1);
      $display("test reset done");
      apb(1, `SLES_IDX_THRESHOLD, 32'h00000003, 0);
      apb(1, `SLES_IDX_IRQ_MASK, 32'h00000008, 0);
      apb(0, `SLES_IDX_IRQ_MASK, 32'h00000008, 0);
      tx_u.send(3, 2);
      tx_u.send(13, 3);
      repeat (3) @(posedge clk);
      apb(0, `SLES_IDX_ERR_FLAGS, 32'h00000000, 0);
      @(negedge clk);
      chk_bit(irq, 1'b0);
      tx_u.send(3, 1);
      repeat (3) @(posedge clk);
      apb(0, `SLES_IDX_ERR_FLAGS, 32'h00000008, 0);
      @(negedge clk);
      chk_bit(irq, 1'b1);
      apb(1, `SLES_IDX_LINK_PAGE, 32'h00000001, 0);
      apb(0, `SLES_IDX_LINK_PAGE, 32'h00000001, 0);
      apb(0, `SLES_IDX_ERR_FLAGS, 32'h00000020, 0);
      apb(0, `SLES_IDX_IRQ_STS, 32'h00002008, 0);
      @(negedge clk);
      chk_bit(irq, 1'b0);
      $display("test threshold done");
      v = $random(seed);
      tx_u.set_lock(v);
      repeat (3) @(posedge clk);
      apb(0, `SLES_IDX_LOCK_FLAGS, {24'h000000, v[15:8]}, 0);
      apb(1, `SLES_IDX_LINK_PAGE, 32'h00000000, 0);
      apb(0, `SLES_IDX_LOCK_FLAGS, {24'h000000, v[7:0]}, 0);
      tx_u.set_lock(~v);
      repeat (3) @(posedge clk);
      apb(0, `SLES_IDX_LOCK_FLAGS, {24'h000000, ~v[7:0]}, 0);
      tx_u.set_lock(16'h0000);
      repeat (3) @(posedge clk);
      apb(0, `SLES_IDX_LOCK_FLAGS, 32'h00000000, 0);
      apb(1, `SLES_IDX_CTRL, 32'h00000001, 0);
      repeat (2) @(posedge clk);
      apb(0, `SLES_IDX_ERR_FLAGS, 32'h00000000, 0);
      apb(1, `SLES_IDX_THRESHOLD, 32'h00000000, 0);
      repeat (2) @(posedge clk);
      apb(0, `SLES_IDX_ERR_FLAGS, 32'h000000FF, 0);
      @(negedge clk);
      chk_bit(irq, 1'b1);
      apb(0, `SLES_IDX_IRQ_STS, 32'h0000FFFF, 0);
      @(negedge clk);
      chk_bit(irq, 1'b0);
      $display("test lock and clear done");
      summarize();
   end
endmodule
